// ===== logic/adc_monitor_defs.vh
// register offsets, field positions, codes and timing for the
// converter monitoring sequencer; definitions only, no logic.
`ifndef ADC_MONITOR_DEFS_VH
`define ADC_MONITOR_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_RESULT_HIGH 8'h07
`define OFS_RESULT_LOW 8'h08
`define OFS_CONVERTER_CONTROL 8'h09
`define OFS_CHANNEL_SELECT 8'h0A
`define OFS_REVERSE_LIMIT 8'h10
`define OFS_REVERSE_STATE 8'h20

// ----------------------------------------
// converter_control fields
// ----------------------------------------
`define BIT_CONVERSION_ENABLE 0
`define BIT_SINGLE_SELECT 1
`define BIT_SWEEP_SELECT 2
`define BIT_BUFFER_DISABLE 3
`define CONTROL_RESET 8'h00

// ----------------------------------------
// channel_select_and_ready fields
// ----------------------------------------
`define CONVERT_SEL_LSB 0
`define READOUT_SEL_LSB 3
`define BIT_RESULT_READY 6
`define CHANNEL_SELECT_RESET 8'h00
`define REVERSE_LIMIT_RESET 8'h00

// ----------------------------------------
// channels and widths
// ----------------------------------------
`define RESULT_WIDTH 12
`define CHANNEL_COUNT 7
`define LAST_CHANNEL 3'h6
`define ALL_CHANNELS_SEEN 7'h7F
`define RESULT_LOW_LSB 2

// ----------------------------------------
// timing
// ----------------------------------------
`define MCLK_FREQ_MHZ 20
`define MUX_SETTLE_NS 1000

`endif

// ===== logic/result_bank.v
// seven result words, one per channel, with a seven-to-one read mux.
// assumes writes and reads come from logic on the same clock.
`timescale 1ns/1ps
`include "adc_monitor_defs.vh"

module result_bank (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // write side
    input wire write_en,
    input wire [2:0] write_channel,
    input wire [`RESULT_WIDTH-1:0] write_data,
    // read side
    input wire [2:0] read_channel,
    output wire [`RESULT_WIDTH-1:0] read_data
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    reg [`RESULT_WIDTH-1:0] results [0:`CHANNEL_COUNT-1];
    integer i;

    always @(posedge clk) begin
        if (!rst_n) begin
            for (i = 0; i < `CHANNEL_COUNT; i = i + 1) begin
                results[i] <= {`RESULT_WIDTH{1'b0}};
            end
        end else if (write_en && write_channel <= `LAST_CHANNEL) begin
            results[write_channel] <= write_data; // [RULE2]
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // unused codes read as zero rather than aliasing a channel
    assign read_data = (read_channel <= `LAST_CHANNEL) ?
                       results[read_channel] : {`RESULT_WIDTH{1'b0}}; // [RULE2]

endmodule

// ===== logic/conversion_pacer.v
// runs one conversion on the shared converter: sets the input mux,
// waits for it to settle, pulses start and catches the result.
// assumes the converter answers with a done pulse on this clock.
`timescale 1ns/1ps
`include "adc_monitor_defs.vh"

module conversion_pacer (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // request side
    input wire go,
    input wire abort,
    input wire [2:0] channel,
    output reg finished,
    output reg [`RESULT_WIDTH-1:0] result,
    // converter side
    output reg mux_select_unused,
    output reg [2:0] mux_channel,
    output reg start,
    input wire conv_done,
    input wire [`RESULT_WIDTH-1:0] conv_data
);

    localparam integer SETTLE_CYCLES =
        (`MUX_SETTLE_NS * `MCLK_FREQ_MHZ + 999) / 1000;
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_SETTLE = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;

    reg [1:0] state;
    reg [7:0] settle_count;

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            settle_count <= 8'h00;
            finished <= 1'b0;
            result <= {`RESULT_WIDTH{1'b0}};
            mux_channel <= 3'h0;
            mux_select_unused <= 1'b0;
            start <= 1'b0;
        end else begin
            finished <= 1'b0;
            start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (go) begin
                        mux_channel <= channel; // [RULE1]
                        mux_select_unused <= (channel > `LAST_CHANNEL);
                        settle_count <= SETTLE_CYCLES[7:0];
                        state <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (abort) begin
                        state <= ST_IDLE;
                    end else if (settle_count == 8'h01) begin
                        start <= 1'b1;
                        state <= ST_WAIT;
                    end else begin
                        settle_count <= settle_count - 8'h01;
                    end
                end
                ST_WAIT: begin
                    if (abort) begin
                        state <= ST_IDLE;
                    end else if (conv_done) begin
                        result <= conv_data;
                        finished <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ===== logic/adc_monitor_sequencer.v
// top of the converter monitoring sequencer: control registers,
// single and polling modes, ready flag and host alert line.
// assumes a register access port fed by the host-side serial slave,
// and an analog converter that answers start with done and data.
//
// Summary of operation
// [RULE1] one 12-bit converter, mux picks channel
// [RULE2] seven result registers, one routed out
// [RULE3] enable bit powers converter on and off
// [RULE4] host sets single mode bits before start
// [RULE5] host sets both channel fields equal
// [RULE6] writing enable 1 starts single conversion
// [RULE7] done sets ready, alert low, enable cleared
// [RULE8] result high and low bytes at 07/08
// [RULE9] alert and ready hold until result read
// [RULE10] host updates channels then sets enable
// [RULE11] host sets polling bits then enable
// [RULE12] polling cycles all channels, overwriting results
// [RULE13] polling ready after every channel converted
// [RULE14] polling never pulls alert low
// [RULE15] host checks ready, then picks readout
// [RULE16] codes 000 to 110 name channels
// [RULE17] host scales output current by limit
// [RULE18] new start clears stale ready flag
// [RULE19] reverse state reads 000 outside reverse
`timescale 1ns/1ps
`include "adc_monitor_defs.vh"

module adc_monitor_sequencer (
    // clock and reset
    input wire MCLK,
    input wire RST_N,
    // register access port
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    output reg REG_RVALID,
    output reg REG_ERROR,
    // host alert line, open drain
    output reg HOST_ALERT_N_OUT,
    output reg HOST_ALERT_N_OE,
    // analog converter
    output reg CONV_POWER,
    output reg CONV_BUFFER_OFF,
    output wire [2:0] CONV_CHANNEL,
    output wire CONV_START,
    input wire CONV_DONE,
    input wire [11:0] CONV_DATA,
    // reverse power mode status
    input wire REVERSE_POWER_MODE,
    input wire [2:0] REVERSE_MODE_STATE
);

    localparam [1:0] MODE_IDLE = 2'b00;
    localparam [1:0] MODE_SINGLE = 2'b01;
    localparam [1:0] MODE_POLL = 2'b10;

    // ----------------------------------------
    // register state
    // ----------------------------------------
    reg [7:0] control;
    reg [2:0] convert_channel_select;
    reg [2:0] readout_channel_select;
    reg result_ready_flag;
    reg [7:0] reverse_limit_setting;
    reg [1:0] mode;
    reg [2:0] poll_channel;
    reg [6:0] seen;
    reg alert_pending;
    reg go;
    reg [2:0] go_channel;

    wire finished;
    wire [11:0] pacer_result;
    wire [11:0] read_result;
    wire unused_code;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function is_write;
        input [7:0] addr;
        input [7:0] ofs;
        input wr;
        begin
            is_write = wr && (addr == ofs);
        end
    endfunction

    function [6:0] channel_bit;
        input [2:0] ch;
        begin
            channel_bit = (ch <= `LAST_CHANNEL) ? (7'h01 << ch) : 7'h00;
        end
    endfunction

    wire wr_control = is_write(REG_ADDR, `OFS_CONVERTER_CONTROL, REG_WR);
    wire wr_channel = is_write(REG_ADDR, `OFS_CHANNEL_SELECT, REG_WR);
    wire wr_limit = is_write(REG_ADDR, `OFS_REVERSE_LIMIT, REG_WR);
    wire rd_result = is_write(REG_ADDR, `OFS_RESULT_HIGH, REG_RD) ||
                     is_write(REG_ADDR, `OFS_RESULT_LOW, REG_RD);

    wire start_write = wr_control &&
                       REG_WDATA[`BIT_CONVERSION_ENABLE] &&
                       !control[`BIT_CONVERSION_ENABLE];
    wire stop_write = wr_control && !REG_WDATA[`BIT_CONVERSION_ENABLE];
    wire single_req = REG_WDATA[`BIT_SINGLE_SELECT] &&
                      !REG_WDATA[`BIT_SWEEP_SELECT];
    wire poll_req = !REG_WDATA[`BIT_SINGLE_SELECT] &&
                    REG_WDATA[`BIT_SWEEP_SELECT];
    wire [2:0] next_poll_channel = (poll_channel == `LAST_CHANNEL) ?
                                   3'h0 : poll_channel + 3'h1;

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always @(posedge MCLK) begin
        if (!RST_N) begin
            control <= `CONTROL_RESET;
            convert_channel_select <= 3'h0;
            readout_channel_select <= 3'h0;
            result_ready_flag <= 1'b0;
            reverse_limit_setting <= `REVERSE_LIMIT_RESET;
            mode <= MODE_IDLE;
            poll_channel <= 3'h0;
            seen <= 7'h00;
            alert_pending <= 1'b0;
            go <= 1'b0;
            go_channel <= 3'h0;
        end else begin
            go <= 1'b0;
            if (wr_channel) begin
                convert_channel_select <= REG_WDATA[2:0];
                readout_channel_select <= REG_WDATA[5:3];
            end
            if (wr_limit) begin
                reverse_limit_setting <= REG_WDATA;
            end
            // a result read releases the alert; ready holds in polling
            if (rd_result && mode != MODE_POLL) begin
                alert_pending <= 1'b0; // [RULE9]
                result_ready_flag <= 1'b0; // [RULE9]
            end
            if (wr_control) begin
                control <= REG_WDATA;
            end
            if (stop_write) begin
                mode <= MODE_IDLE;
            end else if (start_write && single_req) begin
                mode <= MODE_SINGLE; // [RULE6]
                result_ready_flag <= 1'b0; // [RULE18]
                alert_pending <= 1'b0;
                go <= 1'b1;
                go_channel <= convert_channel_select; // [RULE16]
            end else if (start_write && poll_req) begin
                mode <= MODE_POLL;
                result_ready_flag <= 1'b0; // [RULE18]
                alert_pending <= 1'b0;
                seen <= 7'h00;
                poll_channel <= 3'h0;
                go <= 1'b1;
                go_channel <= 3'h0; // [RULE12]
            end else if (finished && mode == MODE_SINGLE) begin
                // event wins over a read landing in the same cycle
                result_ready_flag <= 1'b1; // [RULE7]
                alert_pending <= 1'b1; // [RULE7]
                mode <= MODE_IDLE;
                if (!(wr_control && REG_WDATA[`BIT_CONVERSION_ENABLE])) begin
                    control[`BIT_CONVERSION_ENABLE] <= 1'b0; // [RULE7]
                end
            end else if (finished && mode == MODE_POLL) begin
                seen <= seen | channel_bit(poll_channel);
                if ((seen | channel_bit(poll_channel)) ==
                    `ALL_CHANNELS_SEEN) begin
                    result_ready_flag <= 1'b1; // [RULE13]
                end
                poll_channel <= next_poll_channel; // [RULE12]
                go <= 1'b1;
                go_channel <= next_poll_channel;
            end else if (start_write) begin
                // no valid mode chosen: nothing to run, drop the start
                control[`BIT_CONVERSION_ENABLE] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // converter and pacer
    // ----------------------------------------
    conversion_pacer pacer (
        .clk(MCLK),
        .rst_n(RST_N),
        .go(go),
        .abort(stop_write),
        .channel(go_channel),
        .finished(finished),
        .result(pacer_result),
        .mux_select_unused(unused_code),
        .mux_channel(CONV_CHANNEL),
        .start(CONV_START),
        .conv_done(CONV_DONE && CONV_POWER),
        .conv_data(CONV_DATA)
    );

    // single mode writes the selected channel; polling the swept one
    result_bank bank (
        .clk(MCLK),
        .rst_n(RST_N),
        .write_en(finished && mode != MODE_IDLE && !unused_code),
        .write_channel(CONV_CHANNEL),
        .write_data(pacer_result),
        .read_channel(readout_channel_select),
        .read_data(read_result)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always @(posedge MCLK) begin
        if (!RST_N) begin
            CONV_POWER <= 1'b0;
            CONV_BUFFER_OFF <= 1'b0;
            HOST_ALERT_N_OUT <= 1'b0;
            HOST_ALERT_N_OE <= 1'b0;
        end else begin
            CONV_POWER <= control[`BIT_CONVERSION_ENABLE]; // [RULE3]
            CONV_BUFFER_OFF <= control[`BIT_BUFFER_DISABLE];
            HOST_ALERT_N_OUT <= 1'b0;
            // polling mode never sets alert_pending
            HOST_ALERT_N_OE <= alert_pending; // [RULE14]
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    always @(posedge MCLK) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
            REG_RVALID <= 1'b0;
            REG_ERROR <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            REG_ERROR <= 1'b0;
            REG_RDATA <= 8'h00;
            if (REG_RD) begin
                case (REG_ADDR)
                    `OFS_RESULT_HIGH: begin
                        REG_RDATA <= read_result[11:4]; // [RULE8]
                    end
                    `OFS_RESULT_LOW: begin
                        REG_RDATA <= {2'b00, read_result[3:0],
                                      2'b00}; // [RULE8]
                    end
                    `OFS_CONVERTER_CONTROL: begin
                        REG_RDATA <= control;
                    end
                    `OFS_CHANNEL_SELECT: begin
                        REG_RDATA <= {1'b0, result_ready_flag,
                                      readout_channel_select,
                                      convert_channel_select};
                    end
                    `OFS_REVERSE_LIMIT: begin
                        REG_RDATA <= reverse_limit_setting;
                    end
                    `OFS_REVERSE_STATE: begin
                        REG_RDATA <= REVERSE_POWER_MODE ?
                                     {5'h00, REVERSE_MODE_STATE} :
                                     8'h00; // [RULE19]
                    end
                    default: begin
                        REG_ERROR <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule

// ===== test/monitor_sva.sv
// concurrent checks on the sequencer's register port, alert and converter.
// assumes a bind to the sequencer top; it sees only that module's ports.
`timescale 1ns/1ps
module monitor_sva (
    // clock and reset
    input wire MCLK,
    input wire RST_N,
    // register port
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_RDATA,
    input wire REG_RVALID,
    input wire REG_ERROR,
    // alert and converter
    input wire HOST_ALERT_N_OUT,
    input wire HOST_ALERT_N_OE,
    input wire CONV_POWER,
    input wire [2:0] CONV_CHANNEL,
    input wire CONV_START,
    input wire CONV_DONE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // ----------------------------------------
    // register port
    // ----------------------------------------
    read_answer_a: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered one cycle later");
    idle_data_a: assert property (!REG_RVALID |-> REG_RDATA == 8'h00)
        else $error("read data not zero outside answer");
    error_data_a: assert property (REG_ERROR |-> REG_RVALID &&
        REG_RDATA == 8'h00) else $error("refused read with data");
    // ----------------------------------------
    // converter and alert
    // ----------------------------------------
    start_pulse_a: assert property (CONV_START |=> !CONV_START)
        else $error("start longer than one cycle");
    start_powered_a: assert property (CONV_START |-> CONV_POWER)
        else $error("start while converter off");
    // the mux needs settling time before a start is allowed
    mux_settle_a: assert property (!$stable(CONV_CHANNEL) |->
        (!CONV_START) [*8]) else $error("start too soon after mux change");
    power_off_a: assert property (REG_WR && REG_ADDR == 8'h09 &&
        !REG_WDATA[0] |-> ##[1:3] !CONV_POWER)
        else $error("converter not switched off");
    alert_drive_a: assert property (HOST_ALERT_N_OUT == 1'b0)
        else $error("alert pin driven high");
    alert_cause_a: assert property ($rose(HOST_ALERT_N_OE) |->
        $past(CONV_DONE, 2) || $past(CONV_DONE, 3))
        else $error("alert without a finished conversion");
    alert_hold_a: assert property ($fell(HOST_ALERT_N_OE) |->
        $past(REG_RD, 2) || $past(REG_RD, 3) || $past(REG_WR, 2) ||
        $past(REG_WR, 3)) else $error("alert released without access");
endmodule

// ===== test/conv_model.sv
// behavioural converter on the sequencer's analog side.
// assumes start pulses on the same clock; answers LATENCY cycles later.
`timescale 1ns/1ps
module conv_model #(
    parameter LATENCY = 5
) (
    input wire clk,
    input wire start,
    input wire [2:0] channel,
    input wire [11:0] bias,
    output reg done,
    output reg [11:0] data
);
    integer count;
    reg [11:0] last;
    wire [11:0] word = {channel, channel ^ 3'h5, 6'h2B} ^ bias;
    initial begin
        done = 1'b0;
        data = 12'h000;
        last = 12'h000;
        count = 0;
    end
    always @(posedge clk) begin
        done <= 1'b0;
        // data is not held after done, so stale capture shows up
        data <= ~last;
        if (start) begin
            count <= LATENCY;
        end else if (count == 1) begin
            done <= 1'b1;
            data <= word;
            last <= word;
            count <= 0;
        end else if (count > 1) begin
            count <= count - 1;
        end
    end
endmodule

// ===== test/tb.sv
// self-checking bench: register tasks, single and polling sequences.
// assumes the sequencer and the converter model share MCLK.
`timescale 1ns/1ps
module tb;
    reg MCLK;
    reg RST_N;
    reg [7:0] REG_ADDR;
    reg [7:0] REG_WDATA;
    reg REG_WR;
    reg REG_RD;
    wire [7:0] REG_RDATA;
    wire REG_RVALID;
    wire REG_ERROR;
    wire HOST_ALERT_N_OUT;
    wire HOST_ALERT_N_OE;
    wire CONV_POWER;
    wire CONV_BUFFER_OFF;
    wire [2:0] CONV_CHANNEL;
    wire CONV_START;
    wire CONV_DONE;
    wire [11:0] CONV_DATA;
    reg REVERSE_POWER_MODE;
    reg [2:0] REVERSE_MODE_STATE;
    reg [11:0] bias;
    integer err_count;
    integer num_checks;
    integer ch;
    integer n;
    reg [7:0] d;
    reg e;
    reg [11:0] w;
    adc_monitor_sequencer adc_monitor_sequencer_inst (.MCLK(MCLK),
        .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID), .REG_ERROR(REG_ERROR),
        .HOST_ALERT_N_OUT(HOST_ALERT_N_OUT),
        .HOST_ALERT_N_OE(HOST_ALERT_N_OE), .CONV_POWER(CONV_POWER),
        .CONV_BUFFER_OFF(CONV_BUFFER_OFF), .CONV_CHANNEL(CONV_CHANNEL),
        .CONV_START(CONV_START), .CONV_DONE(CONV_DONE),
        .CONV_DATA(CONV_DATA), .REVERSE_POWER_MODE(REVERSE_POWER_MODE),
        .REVERSE_MODE_STATE(REVERSE_MODE_STATE));
    conv_model conv_model_inst (.clk(MCLK), .start(CONV_START),
        .channel(CONV_CHANNEL), .bias(bias), .done(CONV_DONE),
        .data(CONV_DATA));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function [11:0] exp_word(input [2:0] c, input [11:0] b);
        exp_word = {c, c ^ 3'h5, 6'h2B} ^ b;
    endfunction
    task check(input string name, input [11:0] seen, input [11:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task write_reg(input [7:0] a, input [7:0] v);
        @(posedge MCLK);
        #1 REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = v;
        @(posedge MCLK);
        #1 REG_WR = 1'b0;
    endtask
    task read_reg(input [7:0] a, output [7:0] v, output er);
        @(posedge MCLK);
        #1 REG_RD = 1'b1;
        REG_ADDR = a;
        @(posedge MCLK);
        #1 REG_RD = 1'b0;
        v = REG_RDATA;
        er = REG_ERROR;
        check("read valid", REG_RVALID, 1'b1);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------
    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end
    initial begin
        #(20000 * 50);
        err_count = err_count + 1;
        complete_run;
    end
    initial begin
        RST_N = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REVERSE_POWER_MODE = 1'b0;
        REVERSE_MODE_STATE = 3'h5;
        bias = 12'h000;
        err_count = 0;
        num_checks = 0;
        repeat (8) @(posedge MCLK);
        #1 RST_N = 1'b1;
        read_reg(8'h09, d, e);
        check("control reset", d, 8'h00);
        read_reg(8'h0A, d, e);
        check("select reset", d, 8'h00);
        read_reg(8'h33, d, e);
        check("unmapped", {e, d}, 9'h100);
        write_reg(8'h10, 8'hA6);
        read_reg(8'h10, d, e);
        check("limit", d, 8'hA6);
        read_reg(8'h20, d, e);
        check("state off", d, 8'h00);
        REVERSE_POWER_MODE = 1'b1;
        read_reg(8'h20, d, e);
        check("state on", d, 8'h05);
        write_reg(8'h09, 8'h08);
        repeat (2) @(posedge MCLK);
        #1 check("buffer off", CONV_BUFFER_OFF, 1'b1);
        write_reg(8'h09, 8'h00);
        $display("test registers done");
        for (ch = 0; ch < 7; ch = ch + 1) begin
            write_reg(8'h0A, {2'b00, ch[2:0], ch[2:0]});
            write_reg(8'h09, 8'h03);
            n = 0;
            while (HOST_ALERT_N_OE !== 1'b1 && n < 300) begin
                @(posedge MCLK);
                #1 n = n + 1;
            end
            check("alert", HOST_ALERT_N_OE, 1'b1);
            check("mux", CONV_CHANNEL, ch[2:0]);
            read_reg(8'h0A, d, e);
            check("ready", d[6], 1'b1);
            read_reg(8'h09, d, e);
            check("enable cleared", d, 8'h02);
            repeat (10) @(posedge MCLK);
            #1 check("alert held", HOST_ALERT_N_OE, 1'b1);
            w = exp_word(ch[2:0], bias);
            read_reg(8'h07, d, e);
            check("high", d, w[11:4]);
            read_reg(8'h08, d, e);
            check("low", d, {2'b00, w[3:0], 2'b00});
            repeat (3) @(posedge MCLK);
            #1 check("alert off", HOST_ALERT_N_OE, 1'b0);
        end
        $display("test single done");
        write_reg(8'h0A, 8'h00);
        write_reg(8'h09, 8'h05);
        read_reg(8'h0A, d, e);
        check("early ready", d[6], 1'b0);
        n = 0;
        while (d[6] !== 1'b1 && n < 200) begin
            read_reg(8'h0A, d, e);
            n = n + 1;
        end
        check("sweep ready", d[6], 1'b1);
        // new words from here on; a full sweep must overwrite all
        bias = 12'h3C5;
        repeat (400) @(posedge MCLK);
        for (ch = 0; ch < 7; ch = ch + 1) begin
            w = exp_word(ch[2:0], bias);
            write_reg(8'h0A, {2'b00, ch[2:0], 3'b000});
            read_reg(8'h07, d, e);
            check("poll high", d, w[11:4]);
            read_reg(8'h08, d, e);
            check("poll low", d, {2'b00, w[3:0], 2'b00});
        end
        check("no alert", HOST_ALERT_N_OE, 1'b0);
        write_reg(8'h09, 8'h04);
        repeat (4) @(posedge MCLK);
        #1 check("power off", CONV_POWER, 1'b0);
        write_reg(8'h09, 8'h05);
        read_reg(8'h0A, d, e);
        check("stale ready", d[6], 1'b0);
        write_reg(8'h09, 8'h04);
        $display("test polling done");
        complete_run;
    end
endmodule
bind adc_monitor_sequencer monitor_sva monitor_sva_inst (.MCLK(MCLK),
    .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .REG_ERROR(REG_ERROR),
    .HOST_ALERT_N_OUT(HOST_ALERT_N_OUT), .HOST_ALERT_N_OE(HOST_ALERT_N_OE),
    .CONV_POWER(CONV_POWER), .CONV_CHANNEL(CONV_CHANNEL),
    .CONV_START(CONV_START), .CONV_DONE(CONV_DONE));
